// >>> bridge_ctl_pkg.sv
/*
 * shared types, timing constants and drive encodings for the bridge protection block.
 * assumes a single 100 MHz system clock and synchronous digital comparator inputs.
 */
package bridge_ctl_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS               = 10;
    localparam int OVERCURRENT_DEGLITCH_TIME_NS = 1000;
    localparam int OVERCURRENT_RETRY_PERIOD_US = 1000;
    localparam int WAKE_TIME_US                = 150;
    localparam int CHOP_OFF_TIME_US            = 20;
    // least times round up
    localparam int OC_DEGLITCH_CYC  = (OVERCURRENT_DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
    localparam int OC_RETRY_CYC     = (OVERCURRENT_RETRY_PERIOD_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
    localparam int WAKE_CYC         = (WAKE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CHOP_OFF_CYC     = (CHOP_OFF_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
    localparam int CNT_W            = 20;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    // gate commands for one bridge: high and low side of each output
    typedef struct packed {
        logic hs1;
        logic ls1;
        logic hs2;
        logic ls2;
    } gate_t;

    // per-switch current-limit flags of one bridge
    typedef struct packed {
        logic hs1;
        logic ls1;
        logic hs2;
        logic ls2;
    } fet_limit_t;

    typedef struct packed {
        logic first;
        logic second;
    } bridge_in_t;

    localparam gate_t GATE_OFF   = 4'h0;
    localparam gate_t GATE_FWD   = 4'h9;   // hs1 + ls2
    localparam gate_t GATE_REV   = 4'h6;   // ls1 + hs2
    localparam gate_t GATE_BRAKE = 4'h5;   // ls1 + ls2
endpackage : bridge_ctl_pkg

// >>> bridge_channel.sv
/*
 * one h-bridge channel: input decode, current chopping and overcurrent shutdown/retry.
 * assumes the parent gates it off while asleep, waking, hot or in lockout.
 */
module bridge_channel #(
    parameter int DEGLITCH_CYC = bridge_ctl_pkg::OC_DEGLITCH_CYC,
    parameter int RETRY_CYC    = bridge_ctl_pkg::OC_RETRY_CYC,
    parameter int OFF_CYC      = bridge_ctl_pkg::CHOP_OFF_CYC
) (
    input  wire  logic                      clk_sys,   // system clock
    input  wire  logic                      rst_b,     // async reset, low
    input  wire  logic                      run,       // bridge allowed to drive
    input  wire  bridge_ctl_pkg::bridge_in_t bin,      // host inputs
    input  wire  bridge_ctl_pkg::fet_limit_t lim,      // per-switch limit flags
    input  wire  logic                      sense_oc,  // sense-pin overcurrent
    input  wire  logic                      trip,      // sense reached trip level
    output bridge_ctl_pkg::gate_t           gate,      // gate commands
    output logic                            oc_fault   // overcurrent shutdown state
);
    localparam int W = bridge_ctl_pkg::CNT_W;
    // refuse timings the shared counter width cannot hold
    if (DEGLITCH_CYC < 1 || RETRY_CYC < 1 || OFF_CYC < 1 || DEGLITCH_CYC >= (1 << W)
        || RETRY_CYC >= (1 << W) || OFF_CYC >= (1 << W)) begin : g_bad_timing
        $error("bridge_channel: bad timing parameters");
    end

    // ------------------------------------------------------------------
    // decode and overcurrent detect
    // ------------------------------------------------------------------
    bridge_ctl_pkg::gate_t dec_gate;
    wire logic oc_now = (|lim) | sense_oc;
    wire logic [1:0] in_v = {bin.first, bin.second};
    assign dec_gate = (in_v == 2'h1) ? bridge_ctl_pkg::GATE_REV :
                      (in_v == 2'h2) ? bridge_ctl_pkg::GATE_FWD :
                      (in_v == 2'h3) ? bridge_ctl_pkg::GATE_BRAKE :
                                       bridge_ctl_pkg::GATE_OFF;

    logic [W-1:0] deg_ff, retry_ff, off_ff;
    logic         oc_ff, chop_ff;
    logic [1:0]   in_q_ff;
    wire logic in_chg  = (in_v != in_q_ff);
    wire logic deg_hit = oc_now && (deg_ff >= W'(DEGLITCH_CYC - 1));

    // deglitch, shutdown and retry; an overcurrent still present after retry restarts it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            deg_ff   <= '0;
            retry_ff <= '0;
            oc_ff    <= 1'b0;
        end else if (!run) begin
            // sleep, heat and lockout wipe the protection state, timers included
            deg_ff   <= '0;
            retry_ff <= '0;
            oc_ff    <= 1'b0;
        end else if (oc_ff) begin
            deg_ff <= '0;
            if (retry_ff == W'(1)) oc_ff <= 1'b0;
            retry_ff <= retry_ff - W'(1);
        end else if (deg_hit) begin
            oc_ff    <= 1'b1;
            retry_ff <= W'(RETRY_CYC);
            deg_ff   <= '0;
        end else begin
            deg_ff <= oc_now ? deg_ff + W'(1) : '0;
        end
    end

    // chopping: brake for the off time, cut short by an input change
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            chop_ff <= 1'b0;
            off_ff  <= '0;
            in_q_ff <= 2'h0;
        end else begin
            in_q_ff <= in_v;
            if (!run || oc_ff || (chop_ff && (in_chg || off_ff == W'(1)))) begin
                chop_ff <= 1'b0;
                off_ff  <= '0;
            end else if (!chop_ff && trip) begin
                chop_ff <= 1'b1;
                off_ff  <= W'(OFF_CYC);
            end else if (chop_ff) off_ff <= off_ff - W'(1);
        end
    end

    // only this bridge is cut on its own overcurrent
    assign gate = (!run || oc_ff) ? bridge_ctl_pkg::GATE_OFF :
                  chop_ff         ? bridge_ctl_pkg::GATE_BRAKE : dec_gate;
    assign oc_fault = oc_ff;
endmodule : bridge_channel

// >>> motor_bridge_fault_and_mode_control.sv
/*
 * top of the protection and mode logic for a dual h-bridge driver: sleep/wake,
 * thermal and undervoltage handling, fault indicator, two bridge channels.
 * assumes comparator flags (undervoltage, thermal, limits) arrive as
 * synchronous digital levels with their analog hysteresis already applied.
 */
// Function
// - deglitched overcurrent turns bridge off, flags fault
// - after retry period re-enable bridge, release fault
// - persisting overcurrent repeats the retry cycle
// - overcurrent disables only the affected bridge
// - high and low switches monitored separately
// - sense threshold counts as overcurrent too
// - over-temperature disables all bridges, flags fault
// - thermal recovery automatic after hysteresis clears
// - undervoltage disables everything, resets all state
// - resume only when supply above rising threshold
// - fault indicator low throughout undervoltage
// - active only when powered, awake, wake elapsed
// - sleep keeps all switches off
// - power-up asleep; wake after wake time high
// - fault mode disables bridge, auto recovery
// - two-input decode: coast, reverse, forward, brake
// - trip brakes for off time, input change ends
module motor_bridge_fault_and_mode_control #(
    parameter int WAKE_CYC     = bridge_ctl_pkg::WAKE_CYC,
    parameter int DEGLITCH_CYC = bridge_ctl_pkg::OC_DEGLITCH_CYC,
    parameter int RETRY_CYC    = bridge_ctl_pkg::OC_RETRY_CYC,
    parameter int OFF_CYC      = bridge_ctl_pkg::CHOP_OFF_CYC
) (
    input  wire  logic                       clk_sys,           // 100 MHz clock
    input  wire  logic                       rst_b,             // async reset, low
    input  wire  logic                       undervoltage,      // supply below lockout band
    input  wire  logic                       over_temp,         // thermal flag, hysteretic
    input  wire  logic                       sleep_request_n,   // sleep request, low
    input  wire  bridge_ctl_pkg::bridge_in_t  bridge_a_in,      // bridge a inputs
    input  wire  bridge_ctl_pkg::bridge_in_t  bridge_b_in,      // bridge b inputs
    input  wire  bridge_ctl_pkg::fet_limit_t  bridge_a_limit,   // bridge a switch limits
    input  wire  bridge_ctl_pkg::fet_limit_t  bridge_b_limit,   // bridge b switch limits
    input  wire  logic [1:0]                 bridge_sense_oc,   // sense overcurrent a/b
    input  wire  logic [1:0]                 bridge_sense_trip, // chop trip a/b
    output bridge_ctl_pkg::gate_t            bridge_a_gate,     // bridge a gates
    output bridge_ctl_pkg::gate_t            bridge_b_gate,     // bridge b gates
    output logic                             active,            // active mode flag
    output logic                             fault_indicator_n_o,  // fault pin out, always 0
    output logic                             fault_indicator_n_oe  // fault pin pull-down on
);
    localparam int W = bridge_ctl_pkg::CNT_W;
    // refuse a wake count the timer cannot hold
    if (WAKE_CYC < 1 || WAKE_CYC >= (1 << W)) begin : g_bad_wake
        $error("motor_bridge_fault_and_mode_control: bad wake count");
    end

    // ------------------------------------------------------------------
    // mode sequencing
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_SLEEP, ST_WAKE, ST_ACTIVE} mode_t;
    mode_t        mode_ff, nxt_mode;
    logic [W-1:0] wake_ff;
    logic         uv_ff;

    // lockout is a synchronous reset of all mode state, so it cannot be glitched mid-edge
    wire logic wake_done = (wake_ff >= W'(WAKE_CYC));
    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            ST_SLEEP:  if (sleep_request_n) nxt_mode = ST_WAKE;
            ST_WAKE:   if (!sleep_request_n) nxt_mode = ST_SLEEP;
                       else if (wake_done) nxt_mode = ST_ACTIVE;
            ST_ACTIVE: if (!sleep_request_n) nxt_mode = ST_SLEEP;
            default:   nxt_mode = ST_SLEEP;
        endcase
        if (undervoltage) nxt_mode = ST_SLEEP;
    end

    // power-up enters sleep; wake timer counts only while request is high
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff <= ST_SLEEP;
            wake_ff <= '0;
            uv_ff   <= 1'b1;
        end else begin
            mode_ff <= nxt_mode;
            uv_ff   <= undervoltage;
            wake_ff <= (nxt_mode == ST_WAKE && mode_ff == ST_WAKE) ? wake_ff + W'(1) :
                       (nxt_mode == ST_WAKE) ? W'(1) : '0;
        end
    end

    // ------------------------------------------------------------------
    // bridges
    // ------------------------------------------------------------------
    wire logic run = (mode_ff == ST_ACTIVE) && !over_temp && !undervoltage;
    logic [1:0] oc_fault;
    bridge_ctl_pkg::gate_t gate_a, gate_b;

    bridge_channel #(.DEGLITCH_CYC(DEGLITCH_CYC), .RETRY_CYC(RETRY_CYC), .OFF_CYC(OFF_CYC))
    u_bridge_a (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .run      (run && !uv_ff),
        .bin      (bridge_a_in),
        .lim      (bridge_a_limit),
        .sense_oc (bridge_sense_oc[0]),
        .trip     (bridge_sense_trip[0]),
        .gate     (gate_a),
        .oc_fault (oc_fault[0])
    );
    bridge_channel #(.DEGLITCH_CYC(DEGLITCH_CYC), .RETRY_CYC(RETRY_CYC), .OFF_CYC(OFF_CYC))
    u_bridge_b (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .run      (run && !uv_ff),
        .bin      (bridge_b_in),
        .lim      (bridge_b_limit),
        .sense_oc (bridge_sense_oc[1]),
        .trip     (bridge_sense_trip[1]),
        .gate     (gate_b),
        .oc_fault (oc_fault[1])
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // gates and flag combinational so a fault cuts drive in the same cycle
    assign bridge_a_gate        = gate_a;
    assign bridge_b_gate        = gate_b;
    assign active               = run;
    assign fault_indicator_n_o  = 1'b0;
    assign fault_indicator_n_oe = undervoltage | uv_ff | over_temp | (|oc_fault);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // one system clock for all; every check sleeps through reset
    property p_uv_off;
        @(posedge clk_sys) disable iff (!rst_b)
        undervoltage |-> (bridge_a_gate == 4'h0 && bridge_b_gate == 4'h0 && fault_indicator_n_oe);
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("drive during lockout");

    property p_hot_off;
        @(posedge clk_sys) disable iff (!rst_b)
        over_temp |-> (bridge_a_gate == 4'h0 && bridge_b_gate == 4'h0 && fault_indicator_n_oe);
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("drive while hot");

    property p_sleep_off;
        @(posedge clk_sys) disable iff (!rst_b)
        $past(!sleep_request_n) |-> (bridge_a_gate == 4'h0 && bridge_b_gate == 4'h0);
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("drive while asleep");

    property p_wake_wait;
        @(posedge clk_sys) disable iff (!rst_b)
        $rose(mode_ff == ST_WAKE) |-> !active [*8];
    endproperty
    a_wake_wait: assert property (p_wake_wait) else $error("active before wake");

    property p_oc_gates;
        @(posedge clk_sys) disable iff (!rst_b)
        oc_fault[0] |-> (bridge_a_gate == 4'h0 && fault_indicator_n_oe);
    endproperty
    a_oc_gates: assert property (p_oc_gates) else $error("bridge a drives in fault");

    property p_oc_b_gates;
        @(posedge clk_sys) disable iff (!rst_b)
        oc_fault[1] |-> (bridge_b_gate == 4'h0 && fault_indicator_n_oe);
    endproperty
    a_oc_b_gates: assert property (p_oc_b_gates) else $error("bridge b drives in fault");

    property p_oc_isolated;
        @(posedge clk_sys) disable iff (!rst_b)
        (oc_fault == 2'h1 && run && !uv_ff && $stable(bridge_b_in) && bridge_b_in == 2'h2
         && !u_bridge_b.chop_ff) |-> bridge_b_gate == 4'h9;
    endproperty
    a_oc_isolated: assert property (p_oc_isolated) else $error("bridge b cut by a");

    property p_decode_brake;
        @(posedge clk_sys) disable iff (!rst_b)
        (run && !uv_ff && oc_fault == 2'h0 && bridge_a_in == 2'h3) |-> bridge_a_gate == 4'h5;
    endproperty
    a_decode_brake: assert property (p_decode_brake) else $error("brake decode wrong");

    sequence s_oc_release;
        $fell(oc_fault[0]);
    endsequence
    property p_retry_release;
        @(posedge clk_sys) disable iff (!rst_b)
        s_oc_release and (run && !uv_ff) |-> (bridge_a_gate == u_bridge_a.dec_gate
                                              || u_bridge_a.chop_ff);
    endproperty
    a_retry_release: assert property (p_retry_release) else $error("no resume on retry");

    property p_fault_or;
        @(posedge clk_sys) disable iff (!rst_b)
        !fault_indicator_n_oe |-> (!over_temp && !undervoltage && oc_fault == 2'h0);
    endproperty
    a_fault_or: assert property (p_fault_or) else $error("fault not reported");

    // a trip seen while driving must brake on the very next cycle
    sequence s_trip_a;
        run && !uv_ff && !oc_fault[0] && !u_bridge_a.chop_ff && bridge_sense_trip[0];
    endsequence
    property p_chop_start;
        @(posedge clk_sys) disable iff (!rst_b)
        s_trip_a ##1 (run && !uv_ff && !oc_fault[0]) |-> bridge_a_gate == bridge_ctl_pkg::GATE_BRAKE;
    endproperty
    a_chop_start: assert property (p_chop_start) else $error("no brake on trip");

    // leaving lockout never lands straight in active mode
    property p_uv_restart;
        @(posedge clk_sys) disable iff (!rst_b)
        $fell(uv_ff) |-> !active;
    endproperty
    a_uv_restart: assert property (p_uv_restart) else $error("active out of lockout");

    // active only follows a served wake time with the request still high
    property p_wake_entry;
        @(posedge clk_sys) disable iff (!rst_b)
        $rose(mode_ff == ST_ACTIVE) |-> ($past(wake_done) && $past(sleep_request_n));
    endproperty
    a_wake_entry: assert property (p_wake_entry) else $error("early active");
endmodule : motor_bridge_fault_and_mode_control

// >>> host_model.sv
/*
 * host controller model: drives the sleep request and both bridge input pairs.
 * assumes the bench posts its wishes just after a rising edge; pins move on the falling edge.
 */
module host_model #(
    parameter int SLEEP_ENTRY_CYC = 3
) (
    input  wire logic                       clk_sys,         // system clock
    input  wire logic                       want_awake,      // bench asks for active
    input  wire logic [1:0]                 want_a,          // wanted bridge a code
    input  wire logic [1:0]                 want_b,          // wanted bridge b code
    output logic                            sleep_request_n, // sleep pin, low = sleep
    output bridge_ctl_pkg::bridge_in_t      bridge_a_in,     // bridge a pins
    output bridge_ctl_pkg::bridge_in_t      bridge_b_in,     // bridge b pins
    output logic                            asleep           // entry time served
);
    int unsigned hold_cnt = 0;

    // ------------------------------------------------------------------
    // pin drive, off the sampling edge
    // ------------------------------------------------------------------
    // one process owns the pins; unknown only until the first falling edge, inside reset
    // sleep counted as reached only after the entry time, never trusted earlier
    always @(negedge clk_sys) begin
        sleep_request_n <= want_awake;
        bridge_a_in     <= want_a;
        bridge_b_in     <= want_b;
        if (want_awake) begin
            hold_cnt <= 0;
        end else if (hold_cnt < SLEEP_ENTRY_CYC) begin
            hold_cnt <= hold_cnt + 1;
        end
    end
    assign asleep = !sleep_request_n && (hold_cnt >= SLEEP_ENTRY_CYC);
endmodule // host_model

// >>> testbench.sv
/*
 * self-checking bench for the bridge protection block with short timing parameters.
 * assumes the host model for sleep and bridge pins and a pull-up on the fault pin.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 10, D = 3, R = 20, O = 5;

    logic clk_sys, rst_b, undervoltage, over_temp, want_awake, active, f_o, f_oe, asleep;
    logic [1:0] want_a, want_b, sense_oc, trip;
    bridge_ctl_pkg::bridge_in_t a_in, b_in;
    bridge_ctl_pkg::fet_limit_t lim_a, lim_b;
    bridge_ctl_pkg::gate_t gate_a, gate_b;
    logic sleep_n;
    wire  fault_n = f_oe ? f_o : 1'b1; // open drain with pull-up
    int   n_mismatch, samples_checked, i, hi, lo;

    host_model host_model_inst (.clk_sys(clk_sys), .want_awake(want_awake), .want_a(want_a),
        .want_b(want_b), .sleep_request_n(sleep_n), .bridge_a_in(a_in), .bridge_b_in(b_in),
        .asleep(asleep));
    motor_bridge_fault_and_mode_control #(.WAKE_CYC(W), .DEGLITCH_CYC(D), .RETRY_CYC(R),
        .OFF_CYC(O)) motor_bridge_fault_and_mode_control_inst (.clk_sys(clk_sys),
        .rst_b(rst_b), .undervoltage(undervoltage), .over_temp(over_temp),
        .sleep_request_n(sleep_n), .bridge_a_in(a_in), .bridge_b_in(b_in),
        .bridge_a_limit(lim_a), .bridge_b_limit(lim_b), .bridge_sense_oc(sense_oc),
        .bridge_sense_trip(trip), .bridge_a_gate(gate_a), .bridge_b_gate(gate_b),
        .active(active), .fault_indicator_n_o(f_o), .fault_indicator_n_oe(f_oe));

    // ------------------------------------------------------------------
    // clock, bench model and check helpers
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // reference decode: {first,second} to {hs1,ls1,hs2,ls2}
    function automatic logic [3:0] exp_gate(input int code, input bit on);
        if (!on) return 4'h0;
        case (code)
            1: return 4'h6;
            2: return 4'h9;
            3: return 4'h5;
            default: return 4'h0;
        endcase
    endfunction
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // both bridges against the model, each one enabled or not
    task automatic chk_gates(input bit on_a, input bit on_b);
        chk("bridge_a_gate", exp_gate(want_a, on_a), gate_a);
        chk("bridge_b_gate", exp_gate(want_b, on_b), gate_b);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // host wishes posted after an edge, pins land on the next falling edge
    task automatic host(input bit awake, input logic [1:0] a, input logic [1:0] b);
        @(posedge clk_sys);
        want_awake <= awake;
        want_a     <= a;
        want_b     <= b;
        @(negedge clk_sys);
        #1;
    endtask
    task automatic test_done;
        $display("counts: %0d checked, %0d mismatches", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++; // run hung
        test_done;
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        {rst_b, undervoltage, over_temp, want_awake, sense_oc, trip} = '0;
        {want_a, want_b, lim_a, lim_b, n_mismatch, samples_checked} = '0;
        void'($urandom(25773));
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys) rst_b = 1'b1;
        // power up asleep, then wake after the wake time
        host(0, 2'h2, 2'h1);
        step(3);
        chk("active", 1'b0, active);
        chk_gates(0, 0);
        host(1, 2'h2, 2'h1);
        step(W);
        chk("active", 1'b0, active);
        step(1);
        chk("active", 1'b1, active);
        chk("fault_n", 1'b1, fault_n);
        $display("test wake done");
        // decode every code on a, random codes on b
        for (i = 0; i < 12; i++) begin
            host(1, i[1:0], 2'($urandom % 4));
            step(1);
            chk_gates(1, 1);
        end
        $display("test decode done");
        // overcurrent from each switch and from the sense pin, bridge a only
        for (i = 0; i < 5; i++) begin
            host(1, 2'h2, 2'h2);
            @(negedge clk_sys);
            if (i < 4) lim_a <= 4'h1 << i;
            else sense_oc <= 2'h1;
            step(D - 1);
            chk_gates(1, 1);
            step(1);
            chk_gates(0, 1);
            chk("fault_n", 1'b0, fault_n);
            @(negedge clk_sys);
            lim_a    <= '0;
            sense_oc <= '0;
            step(R - 1);
            chk_gates(0, 1);
            step(1);
            chk_gates(1, 1);
            chk("fault_n", 1'b1, fault_n);
        end
        // persisting overcurrent keeps retrying
        @(negedge clk_sys) sense_oc <= 2'h3;
        {hi, lo} = '0;
        for (i = 0; i < 2 * (R + D + 2); i++) begin
            step(1);
            if (fault_n === 1'b1) hi++;
            else lo++;
        end
        chk("retry_seen", 1'b1, 1'(hi > 0 && lo > R));
        @(negedge clk_sys) sense_oc <= '0;
        step(R + 2);
        $display("test overcurrent done");
        // chop: brake for the off time, an input change ends it early
        host(1, 2'h2, 2'h1);
        @(negedge clk_sys) trip <= 2'h1;
        @(negedge clk_sys) trip <= 2'h0;
        step(1);
        chk("chop_gate", 4'h5, gate_a);
        step(O - 2);
        chk("chop_gate", 4'h5, gate_a);
        step(1);
        chk_gates(1, 1);
        @(negedge clk_sys) trip <= 2'h1;
        @(negedge clk_sys) trip <= 2'h0;
        host(1, 2'h1, 2'h1);
        step(2);
        chk_gates(1, 1);
        $display("test chop done");
        // thermal shutdown and automatic recovery
        @(negedge clk_sys) over_temp <= 1'b1;
        step(1);
        chk_gates(0, 0);
        chk("fault_n", 1'b0, fault_n);
        @(negedge clk_sys) over_temp <= 1'b0;
        step(2);
        chk_gates(1, 1);
        chk("fault_n", 1'b1, fault_n);
        $display("test thermal done");
        // undervoltage lockout resets the mode, wake again afterwards
        // a pending overcurrent retry must not survive the lockout
        @(negedge clk_sys) sense_oc <= 2'h1;
        step(D);
        chk("fault_n", 1'b0, fault_n);
        @(negedge clk_sys) sense_oc <= '0;
        @(negedge clk_sys) undervoltage <= 1'b1;
        step(3);
        chk_gates(0, 0);
        chk("fault_n", 1'b0, fault_n);
        @(negedge clk_sys) undervoltage <= 1'b0;
        step(3);
        chk("active", 1'b0, active);
        chk("fault_n", 1'b1, fault_n);
        step(W + 2);
        chk("active", 1'b1, active);
        chk_gates(1, 1);
        $display("test undervoltage done");
        // sleep request shuts everything off
        host(0, 2'h2, 2'h2);
        step(4);
        chk("active", 1'b0, active);
        chk_gates(0, 0);
        chk("asleep", 1'b1, asleep);
        $display("test sleep done");
        test_done;
    end
endmodule // testbench
